// ==== hdl/meter_ctl.sv ====
// user input function decode, max/min capture and service sequencing
// assumes apb master, input sample and user input synchronous to pclk
// Contract
// - extrapolate display beyond scaling points by slope
// - zero edge sets offset so display reads zero
// - reset edge loads assigned extremes with display
// - hold freezes assigned display while input active
// - display select advances one per edge
// - intensity rises one level per edge, wrapping from 5 to 1
// - print request starts serial transmission
// - print then momentary reset of assigned values
// - setpoint reset clears chosen latched outputs
// - assignment used only for reset, hold, print-reset
// - user input polarity configurable
// - separate max and min capture enables
// - max captured after delay above, to 9999s
// - min captured after delay below, to 999.9s
// - code 66 restores defaults, shows reset
// - code 50 shows model and version
// - calibration step shows busy about 8 seconds
`include "meter_ctl_cfg.svh"
module meter_ctl #(
   parameter int unsigned TENTH_CYCLES = `TENTH_CYCLES,
   parameter int unsigned CAL_CYCLES   = `CAL_BUSY_S * `CLK_HZ,
   parameter logic [7:0]  MODEL_ID     = 8'h5a, // arbitrary value
   parameter logic [7:0]  FW_VERSION   = 8'h10  // arbitrary value
) (
   // apb
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic [31:0]                   prdata,
   output logic                          pready,
   output logic                          pslverr,
   // measurement and user input
   input  wire meter_ctl_pkg::val_type   sample,
   input  wire logic                     user_in,
   input  wire logic                     print_done,
   input  wire logic                     cal_confirm,
   // effects
   output meter_ctl_pkg::val_type        shown_value,
   output logic                          print_start,
   output logic                          sp1_clear,
   output logic                          sp2_clear,
   output logic                          prog_lock,
   output logic [1:0]                    disp_index,
   output logic [2:0]                    intensity,
   output logic                          defaults_load,
   output logic                          cal_busy
);
   import meter_ctl_pkg::*;

   if (TENTH_CYCLES < 1 || CAL_CYCLES < 1) begin : g_bad_counts
      $error("meter_ctl: cycle counts must be at least one");
   end

   logic [31:0] ctrl_q;
   val_type     in1_q, in2_q, dsp1_q, display_point_two_q, offset_q;
   logic [16:0] max_dly_q, min_dly_q;
   val_type     max_q, min_q, display, held_q;
   logic        act_q, hold_act, edge_act, prt_pend_q, prt_rst_q;
   svc_type     svc_q;
   logic [31:0] svc_cnt_q;
   logic        svc_wr;
   logic [7:0]  svc_code;

   func_type   func;
   assign_type asg;
   logic       wr, rd, act;
   assign func = func_type'(ctrl_q[`CTRL_FUNC_LSB +: 4]);
   assign asg  = assign_type'(ctrl_q[`CTRL_ASSIGN_LSB +: 2]);
   assign wr   = psel && penable && pwrite;
   assign rd   = psel && !penable && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // polarity applied before any function sees the input
   assign act = ctrl_q[`CTRL_ACT_HIGH] ? user_in : !user_in;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_q <= 1'b0;
      end else begin
         act_q <= act;
      end
   end
   assign edge_act = act && !act_q;
   assign hold_act = act && func == func_hold;

   function automatic logic uses_assign(input func_type f);
      uses_assign = (f == func_reset || f == func_hold || f == func_prt_rst);
   endfunction

   function automatic logic [16:0] clamp(input logic [16:0] v, input logic [16:0] lim);
      clamp = (v > lim) ? lim : v;
   endfunction

   scale_calc u_scale (
      .pclk    (pclk),
      .presetn (presetn),
      .in1     (in1_q),
      .in2     (in2_q),
      .dsp1    (dsp1_q),
      .display_point_two    (display_point_two_q),
      .offset  (offset_q),
      .sample  (sample),
      .display (display)
   );

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q    <= `CTRL_RESET;
         in1_q     <= '0;
         in2_q     <= 32'sd1;
         dsp1_q    <= '0;
         display_point_two_q    <= 32'sd1;
         max_dly_q <= '0;
         min_dly_q <= '0;
      end else if (defaults_load) begin
         ctrl_q    <= `CTRL_RESET;
         in1_q     <= '0;
         in2_q     <= 32'sd1;
         dsp1_q    <= '0;
         display_point_two_q    <= 32'sd1;
         max_dly_q <= '0;
         min_dly_q <= '0;
      end else if (wr) begin
         case (paddr)
            `OFF_CTRL:       ctrl_q    <= pwdata;
            `OFF_SCALE_IN1:  in1_q     <= pwdata;
            `OFF_SCALE_IN2:  in2_q     <= pwdata;
            `OFF_SCALE_DSP1: dsp1_q    <= pwdata;
            `OFF_SCALE_DISPLAY_POINT_TWO: display_point_two_q    <= pwdata;
            `OFF_MAX_DELAY:  max_dly_q <= clamp(pwdata[16:0], `MAX_DELAY_LIMIT);
            `OFF_MIN_DELAY:  min_dly_q <= clamp(pwdata[16:0], `MIN_DELAY_LIMIT);
            default: ;
         endcase
      end
   end

   // offset: software write or zero edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         offset_q <= '0;
      end else if (defaults_load) begin
         offset_q <= '0;
      end else if (edge_act && func == func_zero) begin
         offset_q <= offset_q - display;
      end else if (wr && paddr == `OFF_OFFSET) begin
         offset_q <= pwdata;
      end
   end

   // display hold snapshot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_q <= '0;
      end else if (!hold_act) begin
         held_q <= (asg == asg_max) ? max_q : (asg == asg_min) ? min_q : display;
      end
   end
   assign shown_value = hold_act ? held_q : display;

   // print request and print-then-reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         print_start <= 1'b0;
         prt_pend_q  <= 1'b0;
         prt_rst_q   <= 1'b0;
      end else begin
         print_start <= edge_act && (func == func_print || func == func_prt_rst);
         if (edge_act && func == func_prt_rst) begin
            prt_pend_q <= 1'b1;
         end else if (print_done) begin
            prt_pend_q <= 1'b0;
         end
         prt_rst_q <= prt_pend_q && print_done;
      end
   end

   // setpoint clears and program lock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp1_clear <= 1'b0;
         sp2_clear <= 1'b0;
         prog_lock <= 1'b0;
      end else begin
         sp1_clear <= edge_act && (func == func_sp1_rst || func == func_sp12_rst);
         sp2_clear <= edge_act && (func == func_sp2_rst || func == func_sp12_rst);
         prog_lock <= act && func == func_lockout;
      end
   end

   // display select and intensity
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disp_index <= '0;
         intensity  <= 3'(`MAX_INTENSITY);
      end else begin
         if (edge_act && func == func_dsel) begin
            disp_index <= (disp_index == 2'(`NUM_DISPLAYS - 1)) ? 2'd0 : disp_index + 2'd1;
         end
         if (edge_act && func == func_bright) begin
            intensity <= (intensity == 3'(`MAX_INTENSITY)) ? 3'd1 : intensity + 3'd1;
         end
      end
   end

   // max/min capture with qualification timers
   logic        ld_ext, max_en, min_en, max_up, min_dn;
   logic [31:0] max_tick_q, min_tick_q;
   logic [16:0] max_ten_q, min_ten_q;
   assign max_en = ctrl_q[`CTRL_MAX_EN];
   assign min_en = ctrl_q[`CTRL_MIN_EN];
   assign ld_ext = (edge_act && func == func_reset) || prt_rst_q;
   assign max_up = max_en && display > max_q && max_ten_q >= max_dly_q;
   assign min_dn = min_en && display < min_q && min_ten_q >= min_dly_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         max_tick_q <= '0;
         max_ten_q  <= '0;
      end else if (!max_en || display <= max_q || max_up) begin
         max_tick_q <= '0;
         max_ten_q  <= '0;
      end else if (max_tick_q == TENTH_CYCLES - 1) begin
         max_tick_q <= '0;
         max_ten_q  <= max_ten_q + 17'd1;
      end else begin
         max_tick_q <= max_tick_q + 32'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         min_tick_q <= '0;
         min_ten_q  <= '0;
      end else if (!min_en || display >= min_q || min_dn) begin
         min_tick_q <= '0;
         min_ten_q  <= '0;
      end else if (min_tick_q == TENTH_CYCLES - 1) begin
         min_tick_q <= '0;
         min_ten_q  <= min_ten_q + 17'd1;
      end else begin
         min_tick_q <= min_tick_q + 32'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         max_q <= '0;
         min_q <= '0;
      end else begin
         if (ld_ext && (asg == asg_max || asg == asg_both)) begin
            max_q <= display;
         end else if (max_up) begin
            max_q <= display;
         end
         if (ld_ext && (asg == asg_min || asg == asg_both)) begin
            min_q <= display;
         end else if (min_dn) begin
            min_q <= display;
         end
      end
   end

   // service code sequencer
   assign svc_wr   = wr && paddr == `OFF_SERVICE;
   assign svc_code = pwdata[7:0];
   assign defaults_load = svc_q == svc_reset;
   assign cal_busy = svc_q == svc_busy;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         svc_q     <= svc_prompt;
         svc_cnt_q <= '0;
      end else begin
         case (svc_q)
            svc_prompt: begin
               svc_cnt_q <= '0;
               if (svc_wr && svc_code == `CODE_DEFAULTS) begin
                  svc_q <= svc_reset;
               end else if (svc_wr && svc_code == `CODE_MODEL) begin
                  svc_q <= svc_model;
               end else if (svc_wr && (svc_code == `CODE_CAL_CURRENT ||
                                       svc_code == `CODE_CAL_VOLT)) begin
                  svc_q <= svc_cal_rd;
               end
            end
            svc_reset: svc_q <= svc_prompt;
            svc_model: if (svc_wr) svc_q <= svc_prompt;
            svc_cal_rd: begin
               if (cal_confirm) begin
                  svc_q <= svc_busy;
               end else if (svc_wr) begin
                  svc_q <= svc_prompt;
               end
            end
            svc_busy: begin
               if (svc_cnt_q == CAL_CYCLES - 1) begin
                  svc_cnt_q <= '0;
                  svc_q     <= svc_cal_rd;
               end else begin
                  svc_cnt_q <= svc_cnt_q + 32'd1;
               end
            end
            default: svc_q <= svc_prompt;
         endcase
      end
   end

   // read path, registered in setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd) begin
         case (paddr)
            `OFF_CTRL:       prdata <= ctrl_q;
            `OFF_SCALE_IN1:  prdata <= in1_q;
            `OFF_SCALE_IN2:  prdata <= in2_q;
            `OFF_SCALE_DSP1: prdata <= dsp1_q;
            `OFF_SCALE_DISPLAY_POINT_TWO: prdata <= display_point_two_q;
            `OFF_OFFSET:     prdata <= offset_q;
            `OFF_MAX_DELAY:  prdata <= {15'h0, max_dly_q};
            `OFF_MIN_DELAY:  prdata <= {15'h0, min_dly_q};
            `OFF_SERVICE:    prdata <= {29'h0, svc_q};
            `OFF_STATUS:     prdata <= {26'h0, cal_busy, prt_pend_q, act, hold_act,
                                        prog_lock, act_q};
            `OFF_INPUT:      prdata <= sample;
            `OFF_DISPLAY:    prdata <= shown_value;
            `OFF_MAXVAL:     prdata <= max_q;
            `OFF_MINVAL:     prdata <= min_q;
            `OFF_MODEL:      prdata <= (svc_q == svc_model) ? {16'h0000, MODEL_ID, FW_VERSION}
                                                            : 32'h0;
            default:         prdata <= 32'h0;
         endcase
      end
   end

   // checks
   a_zero_offset: assert property (@(posedge pclk) disable iff (!presetn)
      edge_act && func == func_zero |=> offset_q == $past(offset_q) - $past(display))
      else $error("zero edge did not null display");
   a_edge_once: assert property (@(posedge pclk) disable iff (!presetn)
      act && act_q |=> !print_start && !sp1_clear && !sp2_clear)
      else $error("edge fired while input held");
   a_sp_clear: assert property (@(posedge pclk) disable iff (!presetn)
      edge_act && func == func_sp12_rst |=> sp1_clear && sp2_clear)
      else $error("setpoint clear missing");
   a_print_go: assert property (@(posedge pclk) disable iff (!presetn)
      edge_act && func == func_print |=> print_start)
      else $error("print not started");
   a_hold_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      hold_act && $past(hold_act) |-> shown_value == $past(shown_value))
      else $error("held display changed");
   a_max_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !max_en && !ld_ext |=> max_q == $past(max_q))
      else $error("max tracked while disabled");
   a_polarity: assert property (@(posedge pclk) disable iff (!presetn)
      func == func_lockout |=> prog_lock == $past(ctrl_q[`CTRL_ACT_HIGH] ~^ user_in))
      else $error("polarity wrong");
   a_dsel_step: assert property (@(posedge pclk) disable iff (!presetn)
      edge_act && func == func_dsel && disp_index == 2'd0 |=> disp_index == 2'd1)
      else $error("display select step wrong");
   a_cal_back: assert property (@(posedge pclk) disable iff (!presetn)
      svc_q == svc_busy && svc_cnt_q == CAL_CYCLES - 1 |=> svc_q == svc_cal_rd)
      else $error("calibration busy did not end");
   c_max_cap: cover property (@(posedge pclk) disable iff (!presetn) max_up);
   c_min_cap: cover property (@(posedge pclk) disable iff (!presetn) min_dn);
   c_prt_rst: cover property (@(posedge pclk) disable iff (!presetn) prt_rst_q);
   c_defaults: cover property (@(posedge pclk) disable iff (!presetn) defaults_load);
endmodule

// ==== hdl/meter_ctl_cfg.svh ====
// constants for the meter user-input, peak-capture and service sequencer
// assumes a 25 MHz pclk and 32-bit apb data
`ifndef METER_CTL_CFG_SVH
`define METER_CTL_CFG_SVH
`define CLK_HZ           25000000
`define TENTH_NS         100000000
`define TENTH_CYCLES     (`CLK_HZ / 10)
`define CAL_BUSY_S       8
`define OFF_CTRL         12'h000
`define OFF_SCALE_IN1    12'h004
`define OFF_SCALE_IN2    12'h008
`define OFF_SCALE_DSP1   12'h00c
`define OFF_SCALE_DISPLAY_POINT_TWO   12'h010
`define OFF_OFFSET       12'h014
`define OFF_MAX_DELAY    12'h018
`define OFF_MIN_DELAY    12'h01c
`define OFF_SERVICE      12'h020
`define OFF_STATUS       12'h024
`define OFF_INPUT        12'h028
`define OFF_DISPLAY      12'h02c
`define OFF_MAXVAL       12'h030
`define OFF_MINVAL       12'h034
`define OFF_MODEL        12'h038
`define CTRL_FUNC_LSB    0
`define CTRL_ASSIGN_LSB  4
`define CTRL_ACT_HIGH    6
`define CTRL_MAX_EN      7
`define CTRL_MIN_EN      8
`define CTRL_RESET       32'h0000_0000
`define NUM_DISPLAYS     3
`define MAX_INTENSITY    5
`define MAX_DELAY_LIMIT  17'd99990
`define MIN_DELAY_LIMIT  17'd9999
`define CODE_DEFAULTS    8'd66
`define CODE_MODEL       8'd50
`define CODE_CAL_CURRENT 8'd40
`define CODE_CAL_VOLT    8'd48
`endif

// ==== hdl/meter_ctl_pkg.sv ====
// types for the meter control block
// assumes meter_ctl_cfg.svh is compiled alongside
package meter_ctl_pkg;
   typedef enum logic [3:0] {
      func_none     = 4'h0,
      func_lockout  = 4'h1,
      func_zero     = 4'h2,
      func_reset    = 4'h3,
      func_hold     = 4'h4,
      func_dsel     = 4'h5,
      func_bright   = 4'h6,
      func_print    = 4'h7,
      func_prt_rst  = 4'h8,
      func_sp1_rst  = 4'h9,
      func_sp2_rst  = 4'ha,
      func_sp12_rst = 4'hb
   } func_type;
   typedef enum logic [1:0] {
      asg_disp = 2'd0,
      asg_max  = 2'd1,
      asg_min  = 2'd2,
      asg_both = 2'd3
   } assign_type;
   typedef enum logic [2:0] {
      svc_prompt = 3'b000,
      svc_reset  = 3'b001,
      svc_model  = 3'b011,
      svc_cal_rd = 3'b010,
      svc_busy   = 3'b110
   } svc_type;
   typedef logic signed [31:0] val_type;
endpackage

// ==== hdl/scale_calc.sv ====
// linear scaling of the input through two coordinate pairs, registered
// assumes in1 differs from in2; equal points give the display1 value plus offset
module scale_calc (
   // clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // scaling points
   input  wire meter_ctl_pkg::val_type   in1,
   input  wire meter_ctl_pkg::val_type   in2,
   input  wire meter_ctl_pkg::val_type   dsp1,
   input  wire meter_ctl_pkg::val_type   display_point_two,
   input  wire meter_ctl_pkg::val_type   offset,
   // conversion
   input  wire meter_ctl_pkg::val_type   sample,
   output meter_ctl_pkg::val_type        display
);
   import meter_ctl_pkg::*;
   logic signed [63:0] num;
   logic signed [31:0] den;
   logic signed [63:0] quo;
   // same slope inside and beyond the points: extrapolation falls out
   always_comb begin
      num = 64'(sample - in1) * 64'(display_point_two - dsp1);
      den = in2 - in1;
      quo = (den == 32'sd0) ? 64'sd0 : num / 64'(den);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         display <= '0;
      end else begin
         display <= val_type'(quo[31:0] + dsp1 + offset);
      end
   end
endmodule

// ==== verification/contact_model.sv ====
// user input contact and serial print link seen from the meter
// assumes bench drives press and polarity just after a rising edge
module contact_model (
   // clock
   input  wire logic pclk,
   // bench control
   input  wire logic press,
   input  wire logic act_high,
   // meter side
   input  wire logic print_start,
   output logic      user_in,
   output logic      print_done
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] lag_q;

   initial begin
      user_in = 1'b1;
      print_done = 1'b0;
      lag_q = 4'h0;
   end

   // contact level under the configured polarity
   always @(posedge pclk) begin
      user_in <= press ~^ act_high;
   end

   // slow printer: finishes some cycles after the request
   always @(posedge pclk) begin
      print_done <= 1'b0;
      if (print_start === 1'b1) begin
         lag_q <= 4'h7;
      end else if (lag_q != 4'h0) begin
         lag_q <= lag_q - 4'h1;
         if (lag_q == 4'h1) begin
            print_done <= 1'b1;
         end
      end
   end
endmodule

// ==== verification/user_input_peak_capture_tb_top.sv ====
// self-checking bench for the meter user input, capture and service logic
// assumes meter_ctl_cfg.svh on the include path and a 25 MHz pclk
`include "meter_ctl_cfg.svh"
module user_input_peak_capture_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import meter_ctl_pkg::*;
   localparam int unsigned TENTH = 10;
   localparam int unsigned CAL   = 50;
   logic        pclk, presetn, psel, penable, pwrite, cal_confirm, press, act_high;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, user_in, print_done, print_start;
   logic        sp1_clear, sp2_clear, prog_lock, defaults_load, cal_busy;
   logic [1:0]  disp_index;
   logic [2:0]  intensity;
   val_type     sample, shown_value;
   int          mismatches, tests_run, n_print, n_sp1, n_sp2, n_dfl;

   meter_ctl #(.TENTH_CYCLES(TENTH), .CAL_CYCLES(CAL)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sample(sample), .user_in(user_in),
      .print_done(print_done), .cal_confirm(cal_confirm),
      .shown_value(shown_value), .print_start(print_start),
      .sp1_clear(sp1_clear), .sp2_clear(sp2_clear), .prog_lock(prog_lock),
      .disp_index(disp_index), .intensity(intensity),
      .defaults_load(defaults_load), .cal_busy(cal_busy));

   contact_model contact (
      .pclk(pclk), .press(press), .act_high(act_high),
      .print_start(print_start), .user_in(user_in), .print_done(print_done));

   initial begin
      pclk = 1'b0;
   end
   always #20 pclk = ~pclk;

   // one-cycle pulses counted as they happen
   always @(posedge pclk) begin
      if (print_start === 1'b1) n_print++;
      if (sp1_clear === 1'b1) n_sp1++;
      if (sp2_clear === 1'b1) n_sp2++;
      if (defaults_load === 1'b1) n_dfl++;
   end

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask

   function automatic logic [31:0] ctrl(input func_type f, input assign_type a,
                                        input logic hi, input logic mx, input logic mn);
      logic [31:0] v;
      v = 32'h0;
      v[3:0] = f;
      v[5:4] = a;
      v[`CTRL_ACT_HIGH] = hi;
      v[`CTRL_MAX_EN] = mx;
      v[`CTRL_MIN_EN] = mn;
      return v;
   endfunction

   // press held n cycles, then released long enough to settle
   task automatic tap(input int n);
      @(posedge pclk);
      press <= 1'b1;
      cyc(n);
      press <= 1'b0;
      cyc(6);
   endtask

   task automatic reset_state;
      chk({29'h0, intensity}, 32'h5);
      chk({30'h0, disp_index}, 32'h0);
      rdchk(12'h03c, 32'h0);
      wr(`OFF_CTRL, ctrl(func_dsel, asg_disp, 1'b0, 1'b0, 1'b0));
      rdchk(`OFF_CTRL, 32'h0000_0005);
   endtask

   // still active low from reset
   task automatic select_and_bright;
      tap(20);
      chk({30'h0, disp_index}, 32'h1);
      tap(1);
      chk({30'h0, disp_index}, 32'h2);
      tap(2);
      chk({30'h0, disp_index}, 32'h0);
      wr(`OFF_CTRL, ctrl(func_bright, asg_disp, 1'b0, 1'b0, 1'b0));
      tap(3);
      chk({29'h0, intensity}, 32'h1);
      tap(3);
      chk({29'h0, intensity}, 32'h2);
      // polarity flips only under no function, so the transient is harmless
      wr(`OFF_CTRL, ctrl(func_none, asg_disp, 1'b1, 1'b0, 1'b0));
      act_high <= 1'b1;
      cyc(4);
   endtask

   task automatic scale_and_zero;
      wr(`OFF_SCALE_IN2, 32'd10);
      wr(`OFF_SCALE_DISPLAY_POINT_TWO, 32'd100);
      sample <= 20;
      cyc(4);
      chk(shown_value, 32'd200);
      sample <= -5;
      cyc(4);
      chk(shown_value, -32'sd50);
      wr(`OFF_CTRL, ctrl(func_zero, asg_disp, 1'b1, 1'b0, 1'b0));
      sample <= 3;
      tap(3);
      chk(shown_value, 32'h0);
      wr(`OFF_OFFSET, 32'h0);
   endtask

   task automatic capture;
      wr(`OFF_MAX_DELAY, 32'h2);
      wr(`OFF_MIN_DELAY, 32'h1);
      wr(`OFF_CTRL, ctrl(func_none, asg_disp, 1'b1, 1'b1, 1'b0));
      sample <= 5;
      cyc(12);
      sample <= 0;
      cyc(30);
      rdchk(`OFF_MAXVAL, 32'h0);
      sample <= 5;
      cyc(12);
      rdchk(`OFF_MAXVAL, 32'h0);
      cyc(28);
      rdchk(`OFF_MAXVAL, 32'd50);
      wr(`OFF_CTRL, ctrl(func_none, asg_disp, 1'b1, 1'b0, 1'b1));
      sample <= 8;
      cyc(40);
      rdchk(`OFF_MAXVAL, 32'd50);
      sample <= -2;
      cyc(30);
      rdchk(`OFF_MINVAL, -32'sd20);
   endtask

   task automatic reset_hold_print;
      wr(`OFF_CTRL, ctrl(func_reset, asg_max, 1'b1, 1'b1, 1'b0));
      sample <= 2;
      tap(4);
      rdchk(`OFF_MAXVAL, 32'd20);
      wr(`OFF_CTRL, ctrl(func_hold, asg_disp, 1'b1, 1'b0, 1'b0));
      press <= 1'b1;
      cyc(4);
      sample <= 7;
      cyc(6);
      chk(shown_value, 32'd20);
      press <= 1'b0;
      cyc(6);
      chk(shown_value, 32'd70);
      wr(`OFF_CTRL, ctrl(func_print, asg_disp, 1'b1, 1'b0, 1'b0));
      n_print = 0;
      tap(10);
      cyc(10);
      chk(n_print, 32'h1);
      wr(`OFF_CTRL, ctrl(func_prt_rst, asg_max, 1'b1, 1'b1, 1'b0));
      sample <= 1;
      tap(2);
      cyc(12);
      chk(n_print, 32'h2);
      rdchk(`OFF_MAXVAL, 32'd10);
   endtask

   task automatic setpoints_and_lock;
      for (int f = 9; f <= 11; f++) begin
         n_sp1 = 0;
         n_sp2 = 0;
         wr(`OFF_CTRL, ctrl(func_type'(f[3:0]), asg_both, 1'b1, 1'b0, 1'b0));
         tap(5);
         chk(n_sp1, (f != 10) ? 32'h1 : 32'h0);
         chk(n_sp2, (f != 9) ? 32'h1 : 32'h0);
      end
      wr(`OFF_CTRL, ctrl(func_lockout, asg_disp, 1'b1, 1'b0, 1'b0));
      press <= 1'b1;
      cyc(4);
      chk(prog_lock, 1'b1);
      press <= 1'b0;
      cyc(4);
      chk(prog_lock, 1'b0);
   endtask

   task automatic service;
      logic [31:0] q;
      wr(`OFF_SERVICE, {24'h0, `CODE_DEFAULTS});
      cyc(5);
      chk(n_dfl, 32'h1);
      rdchk(`OFF_CTRL, `CTRL_RESET);
      wr(`OFF_SERVICE, {24'h0, `CODE_MODEL});
      apb(1'b0, `OFF_SERVICE, 32'h0, q);
      chk({29'h0, q[2:0]}, {29'h0, svc_model});
      // any code leaves the model view; a second one, code 48, enters calibration
      wr(`OFF_SERVICE, 32'h0);
      wr(`OFF_SERVICE, {24'h0, `CODE_CAL_VOLT});
      @(posedge pclk);
      cal_confirm <= 1'b1;
      @(posedge pclk);
      cal_confirm <= 1'b0;
      cyc(3);
      chk(cal_busy, 1'b1);
      cyc(CAL + 5);
      chk(cal_busy, 1'b0);
   endtask

   initial begin
      {presetn, psel, penable, pwrite, cal_confirm, press, act_high} = 7'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      sample = 0;
      {mismatches, tests_run, n_print, n_sp1, n_sp2, n_dfl} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      reset_state();
      select_and_bright();
      scale_and_zero();
      capture();
      reset_hold_print();
      setpoints_and_lock();
      service();
      test_done();
   end

   // whole run needs well under 2000 cycles
   initial begin
      #(40 * 20000);
      mismatches++;
      test_done();
   end
endmodule
